// >>> apsmc_aux_pin_ctrl.sv
// Top of the auxiliary pin mode controller: pin roles, timing source
// selection and sample restart requests for the sample sequencer.
// Assumes the sequencer reports exposure state and takes the restart
// and timing ticks produced here; pins are split into in/out/enable.
`timescale 1ns/100ps
module apsmc_aux_pin_ctrl (
  input  wire logic                    ref_clk,       // 50 MHz clock
  input  wire logic                    srst,          // Sync reset, high
  input  wire logic [3:0]              fsel,          // Function select
  input  wire logic                    swResyncWr,    // Write 1 to resync
  input  wire apsmc_pkg::apsmc_seq_stat_t seqStat,    // Sequencer status
  input  wire logic                    auxPinOneIn,   // Pin one level
  output logic                         auxPinOneOut,  // Pin one drive
  output logic                         auxPinOneOeN,  // Pin one enable, low
  input  wire logic                    auxPinTwoIn,   // Pin two level
  output logic                         auxPinTwoOut,  // Pin two drive
  output logic                         auxPinTwoOeN,  // Pin two enable, low
  output logic                         softwareResyncBit, // Pending bit
  output logic                         sampleStart,   // Start sample pulse
  output logic                         exposureStart, // Start exposure pulse
  output logic                         sampleAbort,   // Abort sample pulse
  output logic                         sampleTick,    // Sample time base
  output logic                         exposureTick,  // Exposure time base
  output logic                         resyncWait     // Waiting for clock
);

  // ****************************************************************
  // Decode and pin inputs
  // ****************************************************************
  apsmc_pkg::apsmc_mode_t mode;
  logic pinOneLvl;
  logic pinOneRaw;
  logic pinOneRise;
  logic pinTwoLvl;
  logic pinTwoRaw;
  logic pinTwoRise;

  apsmc_mode_decode u_decode (
    .fsel (fsel),
    .mode (mode)
  );

  apsmc_edge_detect u_pin_one (
    .ref_clk (ref_clk),
    .srst    (srst),
    .din     (auxPinOneIn),
    .level   (pinOneLvl),
    .rise    (pinOneRaw)
  );

  apsmc_edge_detect u_pin_two (
    .ref_clk (ref_clk),
    .srst    (srst),
    .din     (auxPinTwoIn),
    .level   (pinTwoLvl),
    .rise    (pinTwoRaw)
  );

  // ****************************************************************
  // Role tests
  // ****************************************************************
  // Pin one's role is asked about by the resync and trigger logic alike.
  function automatic logic pinOneIs(
    input apsmc_pkg::apsmc_mode_t    m, // Decoded roles
    input apsmc_pkg::apsmc_p1_role_t r  // Role asked about
  );
    return (m.p1 == r);
  endfunction

  // ****************************************************************
  // Edge masking after a mode change
  // ****************************************************************
  // A new select may release a pin that this block was driving, and the
  // synchroniser still carries that drive for a few cycles. An edge seen
  // then is our own, not the far side's, so it is masked; the price is
  // that a genuine edge in the same few cycles is lost as well. The mask
  // also covers the cycles after reset, when a pin held high by the far
  // side would otherwise look like a fresh rise.
  logic [3:0] fselPrev;
  logic [2:0] settle;
  logic       pinQuiet;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      fselPrev <= 4'h0;
    end else begin
      fselPrev <= fsel;
    end
  end

  // The shift register spans both synchroniser stages and the edge stage.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      settle <= 3'h7;
    end else begin
      settle <= {settle[1:0], fsel != fselPrev};
    end
  end

  // The live compare covers the cycle in which the select has just moved.
  assign pinQuiet   = ~|settle & (fsel == fselPrev);
  assign pinOneRise = pinOneRaw & pinQuiet;
  assign pinTwoRise = pinTwoRaw & pinQuiet;

  // ****************************************************************
  // Internal oscillator tick
  // ****************************************************************
  // A phase accumulator stands in for the 32768 Hz oscillator; jitter
  // is one ref_clk period, which the sequencer tolerates.
  logic [31:0] oscPhase;
  logic        oscTick;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      oscPhase <= '0;
      oscTick  <= 1'b0;
    end else begin
      {oscTick, oscPhase} <= {1'b0, oscPhase} +
                             {1'b0, apsmc_pkg::INT_OSC_STEP};
    end
  end

  // ****************************************************************
  // Timing source selection
  // ****************************************************************
  // The external clock is trusted to be 32768 or 32000 Hz; its rate is
  // not checked here.
  logic extTick;
  assign extTick = pinTwoRise & (mode.p2 == apsmc_pkg::P2_CLK);

  // A timing taken from pin one (smpPin, expPin) gives no tick here: it reaches
  // the sequencer as start pulses instead.

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      sampleTick   <= 1'b0;
      exposureTick <= 1'b0;
    end else begin
      sampleTick   <= mode.smpExt ? extTick :
                      (mode.smpPin ? 1'b0 : oscTick);
      exposureTick <= mode.expExt ? extTick :
                      (mode.expPin ? 1'b0 : oscTick);
    end
  end

  // ****************************************************************
  // Software resync bit
  // ****************************************************************
  // The bit is set by the write and cleared one cycle later once the
  // abort and restart have been issued; a write in that cycle sets again.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      softwareResyncBit <= 1'b0;
    end else begin
      softwareResyncBit <= swResyncWr;
    end
  end

  // ****************************************************************
  // Hardware resync state machine
  // ****************************************************************
  // Leaving the resync select while waiting drops the wait without a
  // restart; the sequencer then runs on whatever timing the new select
  // gives it.
  typedef enum logic [0:0] {
    RS_IDLE = 1'b0,
    RS_WAIT = 1'b1
  } apsmc_rs_state_t;

  apsmc_rs_state_t rsState;
  apsmc_rs_state_t next_rsState;

  always_comb begin
    next_rsState = rsState;
    case (rsState)
      RS_IDLE: begin
        if (pinOneIs(mode, apsmc_pkg::P1_RESYNC) && pinOneRise) begin
          next_rsState = RS_WAIT;
        end
      end
      RS_WAIT: begin
        if (!pinOneIs(mode, apsmc_pkg::P1_RESYNC) || pinTwoRise) begin
          next_rsState = RS_IDLE;
        end
      end
      default: begin
        next_rsState = RS_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      rsState <= RS_IDLE;
    end else begin
      rsState <= next_rsState;
    end
  end

  assign resyncWait = (rsState == RS_WAIT);

  // ****************************************************************
  // Sample control pulses
  // ****************************************************************
  // A software resync and a pin event in one cycle merge into a single
  // abort and start; the sequencer cannot tell them apart and need not.
  logic hwAbort;
  logic hwRestart;
  logic slvSample;
  logic slvExposure;

  assign hwAbort   = (rsState == RS_IDLE) & (next_rsState == RS_WAIT);
  assign hwRestart = (rsState == RS_WAIT) & pinTwoRise &
                     pinOneIs(mode, apsmc_pkg::P1_RESYNC);
  assign slvSample   = pinOneIs(mode, apsmc_pkg::P1_SMP_IN) &
                       pinOneRise;
  assign slvExposure = pinOneIs(mode, apsmc_pkg::P1_EXP_IN) &
                       pinOneRise;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      sampleAbort   <= 1'b0;
      sampleStart   <= 1'b0;
      exposureStart <= 1'b0;
    end else begin
      sampleAbort   <= swResyncWr | hwAbort;
      sampleStart   <= swResyncWr | hwRestart | slvSample |
                       slvExposure;
      exposureStart <= slvExposure;
    end
  end

  // ****************************************************************
  // Pin drivers
  // ****************************************************************
  // Outputs are registered so that a select change never glitches a pin
  // that a second device or an LED multiplexer may be watching. The mux
  // level follows the sequencer one cycle late, which is far below the
  // length of an exposure.
  logic muxActive;
  logic muxLevel;

  assign muxActive = seqStat.slotAbcUsed;
  assign muxLevel  = seqStat.exposureActive & seqStat.expHiDriver;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      auxPinOneOut <= 1'b0;
      auxPinOneOeN <= 1'b1;
    end else begin
      case (mode.p1)
        apsmc_pkg::P1_MUX: begin
          auxPinOneOut <= muxLevel;
          auxPinOneOeN <= ~muxActive;
        end
        apsmc_pkg::P1_SMP_OUT: begin
          auxPinOneOut <= seqStat.sampleActive;
          auxPinOneOeN <= 1'b0;
        end
        apsmc_pkg::P1_EXP_OUT: begin
          auxPinOneOut <= seqStat.exposureActive;
          auxPinOneOeN <= 1'b0;
        end
        default: begin
          auxPinOneOut <= 1'b0;
          auxPinOneOeN <= 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      auxPinTwoOut <= 1'b0;
      auxPinTwoOeN <= 1'b1;
    end else if (mode.p2 == apsmc_pkg::P2_MUX) begin
      auxPinTwoOut <= muxLevel;
      auxPinTwoOeN <= ~muxActive;
    end else begin
      auxPinTwoOut <= 1'b0;
      auxPinTwoOeN <= 1'b1;
    end
  end

  // Unused here: the settled pin levels are kept for the edge logic only.
  logic unusedLvl;
  assign unusedLvl = pinOneLvl ^ pinTwoLvl;

endmodule // apsmc_aux_pin_ctrl

// >>> apsmc_pkg.sv
// Package for the auxiliary pin mode controller: mode codes, decoded
// pin roles and the packed carriers shared by the design files.
// Assumes a single 50 MHz clock domain with synchronous reset.
package apsmc_pkg;

  // ****************************************************************
  // Function select codes
  // ****************************************************************
  localparam logic [3:0] FSEL_MUX_INT     = 4'h0;
  localparam logic [3:0] FSEL_MUX_EXTCLK  = 4'h1;
  localparam logic [3:0] FSEL_SLV_SMP     = 4'h2;
  localparam logic [3:0] FSEL_SLV_SMP_EXT = 4'h3;
  localparam logic [3:0] FSEL_MST_SMP     = 4'h4;
  localparam logic [3:0] FSEL_MST_SMP_EXT = 4'h5;
  localparam logic [3:0] FSEL_SLV_EXP     = 4'h6;
  localparam logic [3:0] FSEL_MST_EXP     = 4'h7;
  localparam logic [3:0] FSEL_MST_EXP_EXT = 4'h8;
  localparam logic [3:0] FSEL_HW_RESYNC   = 4'h9;
  localparam logic [3:0] FSEL_RESET       = 4'h0;

  // ****************************************************************
  // Timing constants
  // ****************************************************************
  localparam int CLK_HZ          = 50_000_000;
  localparam int INT_OSC_HZ      = 32768;
  // Phase accumulator step for the internal timing tick, 32-bit phase.
  localparam logic [31:0] INT_OSC_STEP =
    32'((64'(INT_OSC_HZ) << 32) / 64'(CLK_HZ));

  // ****************************************************************
  // Decoded roles
  // ****************************************************************
  typedef enum logic [2:0] {
    P1_MUX     = 3'b000,
    P1_SMP_IN  = 3'b001,
    P1_SMP_OUT = 3'b010,
    P1_EXP_IN  = 3'b011,
    P1_EXP_OUT = 3'b100,
    P1_RESYNC  = 3'b101
  } apsmc_p1_role_t;

  typedef enum logic [1:0] {
    P2_OFF = 2'b00,
    P2_MUX = 2'b01,
    P2_CLK = 2'b10
  } apsmc_p2_role_t;

  typedef struct packed {
    apsmc_p1_role_t p1;
    apsmc_p2_role_t p2;
    logic           smpExt;  // Sample timing from the pin two clock.
    logic           expExt;  // Exposure timing from the pin two clock.
    logic           smpPin;  // Sample timing from pin one.
    logic           expPin;  // Exposure timing from pin one.
  } apsmc_mode_t;

  // Pin output pair: output enable is low while the module drives the pin.
  typedef struct packed {
    logic dout;
    logic oeN;
  } apsmc_pin_out_t;

  // Sequencer status seen by the pin logic.
  typedef struct packed {
    logic slotAbcUsed;   // Some sequence slot uses states A, B or C.
    logic expHiDriver;   // Exposure running on driver four, five or six.
    logic sampleActive;  // A sample is being taken.
    logic exposureActive;
  } apsmc_seq_stat_t;

endpackage : apsmc_pkg

// >>> apsmc_mode_decode.sv
// Decodes the 4-bit function select into pin roles and timing sources.
// Purely combinational; the select is assumed stable between writes.
`timescale 1ns/100ps
module apsmc_mode_decode (
  input  wire logic [3:0]          fsel, // Function select
  output apsmc_pkg::apsmc_mode_t   mode  // Decoded roles
);

  // ****************************************************************
  // Decode
  // ****************************************************************
  always_comb begin
    mode        = '0;
    mode.p1     = apsmc_pkg::P1_MUX;
    mode.p2     = apsmc_pkg::P2_OFF;
    case (fsel)
      apsmc_pkg::FSEL_MUX_INT: begin
        mode.p1 = apsmc_pkg::P1_MUX;
      end
      apsmc_pkg::FSEL_MUX_EXTCLK: begin
        mode.p2     = apsmc_pkg::P2_CLK;
        mode.smpExt = 1'b1;
        mode.expExt = 1'b1;
      end
      apsmc_pkg::FSEL_SLV_SMP: begin
        mode.p1     = apsmc_pkg::P1_SMP_IN;
        mode.p2     = apsmc_pkg::P2_MUX;
        mode.smpPin = 1'b1;
      end
      apsmc_pkg::FSEL_SLV_SMP_EXT: begin
        mode.p1     = apsmc_pkg::P1_SMP_IN;
        mode.p2     = apsmc_pkg::P2_CLK;
        mode.smpPin = 1'b1;
        mode.expExt = 1'b1;
      end
      apsmc_pkg::FSEL_MST_SMP: begin
        mode.p1 = apsmc_pkg::P1_SMP_OUT;
        mode.p2 = apsmc_pkg::P2_MUX;
      end
      apsmc_pkg::FSEL_MST_SMP_EXT: begin
        mode.p1     = apsmc_pkg::P1_SMP_OUT;
        mode.p2     = apsmc_pkg::P2_CLK;
        mode.expExt = 1'b1;
      end
      apsmc_pkg::FSEL_SLV_EXP: begin
        mode.p1     = apsmc_pkg::P1_EXP_IN;
        mode.p2     = apsmc_pkg::P2_MUX;
        mode.smpPin = 1'b1;
        mode.expPin = 1'b1;
      end
      apsmc_pkg::FSEL_MST_EXP: begin
        mode.p1 = apsmc_pkg::P1_EXP_OUT;
        mode.p2 = apsmc_pkg::P2_MUX;
      end
      apsmc_pkg::FSEL_MST_EXP_EXT: begin
        mode.p1     = apsmc_pkg::P1_EXP_OUT;
        mode.p2     = apsmc_pkg::P2_CLK;
        mode.smpExt = 1'b1;
        mode.expExt = 1'b1;
      end
      apsmc_pkg::FSEL_HW_RESYNC: begin
        mode.p1     = apsmc_pkg::P1_RESYNC;
        mode.p2     = apsmc_pkg::P2_CLK;
        mode.smpExt = 1'b1;
        mode.expExt = 1'b1;
      end
      default: begin
        mode.p1 = apsmc_pkg::P1_MUX;
      end
    endcase
  end

endmodule // apsmc_mode_decode

// >>> apsmc_edge_detect.sv
// Two-stage synchroniser followed by a rising edge detector.
// Input is asynchronous pin level; output is a one-cycle pulse.
`timescale 1ns/100ps
module apsmc_edge_detect (
  input  wire logic ref_clk, // 50 MHz clock
  input  wire logic srst,    // Synchronous reset, active high
  input  wire logic din,     // Pin level
  output logic      level,   // Synchronised level
  output logic      rise     // One-cycle pulse on a rising edge
);

  // ****************************************************************
  // Synchroniser and edge
  // ****************************************************************
  logic meta;
  logic prev;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      meta  <= 1'b0;
      level <= 1'b0;
      prev  <= 1'b0;
    end else begin
      meta  <= din;
      level <= meta;
      prev  <= level;
    end
  end

  // The first stage is never looked at; only settled levels are compared.
  assign rise = level & ~prev;

endmodule // apsmc_edge_detect

// >>> apsmc_aux_pin_ctrl_chk.sv
// Checker for the auxiliary pin mode controller: pin roles per select
// and resync pulses. Sees only the top module's ports; bound below.
`timescale 1ns/100ps
module apsmc_aux_pin_ctrl_chk (
  input wire logic                       ref_clk,           // Clock
  input wire logic                       srst,              // Reset
  input wire logic [3:0]                 fsel,              // Select
  input wire logic                       swResyncWr,        // Resync write
  input wire apsmc_pkg::apsmc_seq_stat_t seqStat,           // Status
  input wire logic                       auxPinOneOut,      // Pin one out
  input wire logic                       auxPinOneOeN,      // Pin one oe
  input wire logic                       auxPinTwoOut,      // Pin two out
  input wire logic                       auxPinTwoOeN,      // Pin two oe
  input wire logic                       softwareResyncBit, // Pending
  input wire logic                       sampleStart,       // Start
  input wire logic                       exposureStart,     // Exposure
  input wire logic                       sampleAbort,       // Abort
  input wire logic                       sampleTick,        // Tick
  input wire logic                       resyncWait         // Waiting
);
  logic muxOne;
  logic muxTwo;
  logic hiLvl;
  assign muxOne = fsel inside {4'h0, 4'h1} || fsel > 4'h9;
  assign muxTwo = fsel inside {4'h2, 4'h4, 4'h6, 4'h7};
  assign hiLvl  = seqStat.exposureActive & seqStat.expHiDriver;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);
  p1_mux_a: assert property (muxOne |=> auxPinOneOeN ==
    !$past(seqStat.slotAbcUsed) && (auxPinOneOeN || auxPinOneOut == $past(hiLvl)))
    else $error("pin one mux level wrong");
  p2_mux_a: assert property (muxTwo |=> auxPinTwoOeN ==
    !$past(seqStat.slotAbcUsed) && (auxPinTwoOeN || auxPinTwoOut == $past(hiLvl)))
    else $error("pin two mux level wrong");
  p2_free_a: assert property (!muxTwo |=> auxPinTwoOeN)
    else $error("pin two driven as input");
  p1_input_a: assert property (fsel inside {4'h2, 4'h3, 4'h6, 4'h9}
    |=> auxPinOneOeN) else $error("pin one driven as input");
  smp_out_a: assert property (fsel inside {4'h4, 4'h5} |=>
    !auxPinOneOeN && auxPinOneOut == $past(seqStat.sampleActive))
    else $error("master sample output wrong");
  exp_out_a: assert property (fsel inside {4'h7, 4'h8} |=>
    !auxPinOneOeN && auxPinOneOut == $past(seqStat.exposureActive))
    else $error("master exposure output wrong");
  sw_resync_a: assert property (swResyncWr |=>
    sampleAbort && sampleStart && softwareResyncBit)
    else $error("software resync not acted on");
  sw_clear_a: assert property (softwareResyncBit |-> $past(swResyncWr))
    else $error("resync bit did not clear");
  rs_enter_a: assert property ($rose(resyncWait) |-> sampleAbort)
    else $error("resync wait without abort");
  rs_leave_a: assert property ($fell(resyncWait) && fsel == 4'h9
    && $past(fsel) == 4'h9 |-> sampleStart && sampleTick)
    else $error("resync restart missing");
  rs_idle_a: assert property (fsel != 4'h9 |=> !resyncWait)
    else $error("resync wait outside mode");
  slave_exp_a: assert property (fsel == 4'h6 && $past(fsel) == 4'h6
    |-> sampleStart == exposureStart) else $error("slave exposure split");
  cover property ($rose(resyncWait));
  cover property (swResyncWr);
  cover property (fsel == 4'h6 && exposureStart);
endmodule // apsmc_aux_pin_ctrl_chk
bind apsmc_aux_pin_ctrl apsmc_aux_pin_ctrl_chk apsmc_aux_pin_ctrl_chk_i (
  .ref_clk, .srst, .fsel, .swResyncWr, .seqStat, .auxPinOneOut,
  .auxPinOneOeN, .auxPinTwoOut, .auxPinTwoOeN, .softwareResyncBit,
  .sampleStart, .exposureStart, .sampleAbort, .sampleTick, .resyncWait);

// >>> apsmc_far_side.sv
// Far side model: trigger source on pin one, external clock on pin two.
// The clock stands low while not asked to run.
`timescale 1ns/100ps
module apsmc_far_side #(parameter int HALF = 763) (
  input  wire logic ref_clk, // 50 MHz clock
  input  wire logic clkRun,  // Run the external clock
  input  wire logic trig,    // Request one trigger pulse
  output logic      pinOne,  // Trigger line
  output logic      pinTwo   // External clock line
);
  int cnt;
  int pw;
  initial begin
    pinOne = 1'b0;
    pinTwo = 1'b0;
    cnt = 0;
    pw = 0;
  end
  always @(posedge ref_clk) begin
    // Half period of 763 cycles gives close to 32768 Hz.
    if (!clkRun) begin
      cnt <= 0;
      pinTwo <= 1'b0;
    end else if (cnt == HALF - 1) begin
      cnt <= 0;
      pinTwo <= !pinTwo;
    end else
      cnt <= cnt + 1;
    pw <= trig ? 10 : (pw > 0 ? pw - 1 : 0);
    pinOne <= trig || pw > 1;
  end
endmodule // apsmc_far_side

// >>> apsmc_aux_pin_ctrl_tb.sv
// Testbench for the auxiliary pin mode controller.
// Assumes the checker is bound to the top; pins resolved here.
`timescale 1ns/100ps
module apsmc_aux_pin_ctrl_tb;
  localparam int HALF = 763;
  logic       ref_clk = 1'b0, srst = 1'b1, swResyncWr = 1'b0;
  logic       clkRun = 1'b0, trig = 1'b0, p2Prev = 1'b0;
  logic [3:0] fsel = 4'h0;
  apsmc_pkg::apsmc_seq_stat_t seqStat = '0;
  logic p1Far, p2Far, p1Out, p1OeN, p2Out, p2OeN, swBit;
  logic sStart, eStart, sAbort, sTick, eTick, rsWait;
  int   n_errors = 0, n_tests = 0, nRise, nSt, nEt, nSs, nEs, nAb;
  wire  p1Pin = p1OeN ? p1Far : p1Out;
  wire  p2Pin = p2OeN ? p2Far : p2Out;
  // Rows: select, status {abc, hi, sample, exposure}, {oeN1,o1,oeN2,o2}.
  logic [11:0] rows [20] = '{12'h0D6, 12'h02A, 12'h1D6, 12'h12A, 12'h2D9,
    12'h22A, 12'h3DA, 12'h4D1, 12'h426, 12'h5D2, 12'h526, 12'h6D9, 12'h7D5,
    12'h722, 12'h8D6, 12'h822, 12'h9DA, 12'hAD6, 12'hF2A, 12'hCD6};
  logic [3:0] extModes [5] = '{4'h1, 4'h3, 4'h5, 4'h8, 4'h9};
  initial forever #10 ref_clk = !ref_clk;
  apsmc_far_side #(.HALF(HALF)) apsmc_far_side_i (.ref_clk(ref_clk),
    .clkRun(clkRun), .trig(trig), .pinOne(p1Far), .pinTwo(p2Far));
  apsmc_aux_pin_ctrl apsmc_aux_pin_ctrl_i (.ref_clk(ref_clk), .srst(srst),
    .fsel(fsel), .swResyncWr(swResyncWr), .seqStat(seqStat),
    .auxPinOneIn(p1Pin), .auxPinOneOut(p1Out), .auxPinOneOeN(p1OeN),
    .auxPinTwoIn(p2Pin), .auxPinTwoOut(p2Out), .auxPinTwoOeN(p2OeN),
    .softwareResyncBit(swBit), .sampleStart(sStart),
    .exposureStart(eStart), .sampleAbort(sAbort), .sampleTick(sTick),
    .exposureTick(eTick), .resyncWait(rsWait));
  always @(posedge ref_clk) begin
    p2Prev <= p2Pin;
    nRise += int'(p2Pin && !p2Prev);
    nSt += int'(sTick);
    nEt += int'(eTick);
    nSs += int'(sStart);
    nEs += int'(eStart);
    nAb += int'(sAbort);
  end
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic clr;
    #1 {nRise, nSt, nEt, nSs, nEs, nAb} = '0;
  endtask
  task automatic pulse(input logic [3:0] m);
    @(posedge ref_clk) fsel <= m;
    repeat (4) @(posedge ref_clk);
    clr();
    @(posedge ref_clk) trig <= 1'b1;
    @(posedge ref_clk) trig <= 1'b0;
    repeat (14) @(posedge ref_clk);
    #1;
  endtask
  task automatic ext_run(input logic [3:0] m, input logic run);
    @(posedge ref_clk) fsel <= m;
    repeat (4) @(posedge ref_clk);
    clr();
    @(posedge ref_clk) clkRun <= run;
    repeat (8 * HALF) @(posedge ref_clk);
    clkRun <= 1'b0;
    repeat (10) @(posedge ref_clk);
    #1;
  endtask
  task automatic report_and_stop;
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    #2_000_000;
    n_errors++;
    $display("watchdog expired");
    report_and_stop();
  end
  initial begin
    repeat (20) @(posedge ref_clk);
    srst <= 1'b0;
    #1 check(16'({p1OeN, p2OeN, sStart, sAbort, sTick, rsWait}), 16'h0030);
    $display("reset test done");
    for (int i = 0; i < 20; i++) begin
      @(posedge ref_clk) fsel <= rows[i][11:8];
      seqStat <= apsmc_pkg::apsmc_seq_stat_t'(rows[i][7:4]);
      repeat (2) @(posedge ref_clk);
      #1 check(16'({p1OeN, p1OeN ? 1'b0 : p1Out, p2OeN,
        p2OeN ? 1'b0 : p2Out}), 16'(rows[i][3:0]));
    end
    $display("pin role table done");
    @(posedge ref_clk) swResyncWr <= 1'b1;
    @(posedge ref_clk) swResyncWr <= 1'b0;
    #1 check(16'({sAbort, sStart, swBit}), 16'h0007);
    @(posedge ref_clk) #1 check(16'(swBit), 16'h0000);
    $display("software resync done");
    pulse(4'h0);
    check(16'(nSs), 16'h0000);
    pulse(4'h2);
    check(16'(nSs), 16'h0001);
    pulse(4'h6);
    check(16'({nSs[3:0], nEs[3:0]}), 16'h0011);
    $display("slave trigger done");
    pulse(4'h9);
    check(16'({rsWait, nAb[3:0], nSs[3:0]}), 16'h0110);
    pulse(4'h9);
    check(16'({rsWait, nAb[3:0]}), 16'h0010);
    @(posedge ref_clk) clkRun <= 1'b1;
    for (int i = 0; i < 2 * HALF + 20 && !sStart; i++)
      @(posedge ref_clk) #1;
    check(16'({sStart, sTick, rsWait}), 16'h0006);
    @(posedge ref_clk) clkRun <= 1'b0;
    $display("hardware resync done");
    for (int i = 0; i < 5; i++) begin
      ext_run(extModes[i], 1'b1);
      check(16'(nRise), 16'h0004);
      check(16'(nEt), 16'(nRise));
      if (i == 1)
        check(16'(nSt), 16'h0000);
      else if (i != 2)
        check(16'(nSt), 16'(nRise));
    end
    ext_run(4'h1, 1'b0);
    check(16'(nSt), 16'h0000);
    ext_run(4'h0, 1'b0);
    check(16'(nSt inside {[3:5]}), 16'h0001);
    $display("timing source done");
    report_and_stop();
  end
endmodule // apsmc_aux_pin_ctrl_tb
